// ### core/pmsr_mgmt_engine.sv
// management engine: timed single read, write and repeated scan
`timescale 1ns/1ps
`default_nettype none
module pmsr_mgmt_engine #(
  parameter int OP_CYC = pmsr_pkg::MGMT_OP_CYC // cycles per management operation
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable, freezes state when low
  pmsr_mgmt_if.eng m // commands in, status and data out
);
  import pmsr_pkg::*;

  localparam int CW = $clog2(OP_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(OP_CYC - 1);

  typedef struct packed {
    pmsr_state_t st;
    logic [CW-1:0] cnt;
    logic read_data_invalid_flag;
    logic done;
    logic [DATA_W-1:0] data;
  } pmsr_eng_t;

  localparam pmsr_eng_t ENG_RST = '{st: ST_IDLE, default: '0};

  pmsr_eng_t s;
  pmsr_eng_t next_s;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // read and write starts are ignored while busy; clearing scan_en ends a scan at its interval end; software must wait for busy low
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    case (s.st)
      ST_IDLE: begin
        next_s.cnt = '0;
        if (m.scan_en) begin
          next_s.st = ST_SCAN;
          next_s.read_data_invalid_flag = 1'b1;
        end else if (m.start_read) begin
          next_s.st = ST_READ;
          next_s.read_data_invalid_flag = 1'b1;
        end else if (m.start_write) begin
          next_s.st = ST_WRITE;
        end
      end
      ST_READ, ST_WRITE, ST_SCAN: begin
        if (s.cnt == LAST) begin
          next_s.cnt = '0;
          if (s.st != ST_WRITE) begin
            next_s.data = m.phy_data;
            next_s.done = 1'b1;
            next_s.read_data_invalid_flag = 1'b0;
          end
          // a cancelled scan still finishes the read in flight
          if (!(s.st == ST_SCAN && m.scan_en)) begin
            next_s.st = ST_IDLE;
          end
        end else begin
          next_s.cnt = s.cnt + 1'b1;
        end
      end
      default: begin
        next_s = ENG_RST;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= ENG_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // status toward the register bank
  assign m.busy = (s.st != ST_IDLE);
  assign m.scanning = (s.st == ST_SCAN);
  assign m.read_data_invalid_flag = s.read_data_invalid_flag;
  assign m.done = s.done;
  assign m.rd_data = s.data;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_read_start;
    ce && s.st == ST_IDLE && !m.scan_en && m.start_read;
  endsequence

  sequence s_scan_wrap;
    ce && s.st == ST_SCAN && s.cnt == LAST;
  endsequence

  chk_read_start: assert property (s_read_start |=> m.busy && m.read_data_invalid_flag)
    else $error("read start did not raise busy and not-valid");
  chk_read_done: assert property (m.done |-> !m.read_data_invalid_flag)
    else $error("read data not-valid flag still set after completion");
  chk_busy_clear: assert property (m.done && !m.scanning |-> !m.busy)
    else $error("busy did not clear itself after the fetch");
  chk_scan_refresh: assert property (s_scan_wrap |=> m.done && m.rd_data == $past(m.phy_data))
    else $error("scan interval did not refresh read data");
  chk_scan_flag: assert property (m.scanning |-> m.busy)
    else $error("scan flag set while engine idle");
endmodule
`default_nettype wire

// ### core/pmsr_regs.sv
// phy management status and identification register bank
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pmsr_regs #(
  parameter logic [pmsr_pkg::OUI_W-1:0] OUI = 22'h2a5a5a, // arbitrary value
  parameter logic [pmsr_pkg::PART_W-1:0] PART_NUM = 6'h15, // arbitrary value
  parameter logic [pmsr_pkg::PREV_W-1:0] PHY_REV = 4'h3, // arbitrary value
  parameter logic [pmsr_pkg::SIREV_W-1:0] SI_REV = 5'h0a, // arbitrary value
  parameter int OP_CYC = pmsr_pkg::MGMT_OP_CYC // cycles per operation
) (
  input wire logic clk, // system clock, 50 mhz
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable
  input wire logic [pmsr_pkg::ADDR_W-1:0] addr, // register offset
  input wire logic [pmsr_pkg::DATA_W-1:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [pmsr_pkg::DATA_W-1:0] rdata, // read data, cycle after rd
  output logic irq, // level interrupt
  input wire logic link_up, // live phy link level
  input wire logic jabber_det, // phy jabber event
  input wire logic [pmsr_pkg::DATA_W-1:0] phy_reg_data // selected phy register
);
  import pmsr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cmd_read;
    logic scan_en;
    logic start_read;
    logic start_write;
    logic link_latch;
    logic link_prev;
    logic jabber;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_en;
    logic [DATA_W-1:0] rdata;
  } pmsr_regs_t;

  localparam pmsr_regs_t REGS_RST = '0;

  pmsr_regs_t s;
  pmsr_regs_t next_s;
  pmsr_mgmt_if m ();

  // one decode used by every write strobe and the phs1 read strobe
  function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = strobe && (a == off);
  endfunction

  // ----------------------------------------------------------------
  // management engine
  // ----------------------------------------------------------------
  pmsr_mgmt_engine #(
    .OP_CYC(OP_CYC)
  ) u_engine (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .m(m)
  );

  // commands leave from flops so the engine sees one clean pulse
  assign m.start_read = s.start_read;
  assign m.start_write = s.start_write;
  assign m.scan_en = s.scan_en;
  assign m.phy_data = phy_reg_data;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic rd_phs1;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    rd_phs1 = hit(rd, addr, OFF_PHS1);
    ev = '0;
    clr = '0;
    next_s = s;
    next_s.start_read = 1'b0;
    next_s.start_write = 1'b0;

    // only command, enable and clear are writable; the rest ignore writes
    if (hit(wr, addr, OFF_MCMD)) begin
      next_s.cmd_read = wdata[CMD_READ_BIT];
      next_s.scan_en = wdata[CMD_SCAN_BIT];
      next_s.start_read = wdata[CMD_READ_BIT];
      next_s.start_write = wdata[CMD_WRITE_BIT];
    end
    if (hit(wr, addr, OFF_IRQ_EN)) begin
      next_s.irq_en = wdata[IRQ_W-1:0];
    end
    if (hit(wr, addr, OFF_IRQ_CLR)) begin
      clr = wdata[IRQ_W-1:0];
    end

    // latch link low: a read reloads the live level, a drop always wins
    if (rd_phs1) begin
      next_s.link_latch = link_up;
    end
    if (!link_up) begin
      next_s.link_latch = 1'b0;
    end

    // latch jabber high: a read clears it unless an event lands then
    if (rd_phs1) begin
      next_s.jabber = 1'b0;
    end
    if (jabber_det) begin
      next_s.jabber = 1'b1;
    end

    // interrupt events; a set in the clearing cycle is kept
    next_s.link_prev = link_up;
    ev[IRQ_DONE_BIT] = m.done;
    ev[IRQ_LINK_BIT] = s.link_prev && !link_up;
    ev[IRQ_JAB_BIT] = jabber_det;
    next_s.irq_st = (s.irq_st & ~clr) | ev;

    // read data stand for one cycle only, zero otherwise
    next_s.rdata = '0;
    if (rd) begin
      case (addr)
        OFF_MSTAT: begin
          // reserved bit 3 and bits 15-4 stay zero
          next_s.rdata[ST_READ_DATA_INVALID_FLAG_BIT] = m.read_data_invalid_flag;
          next_s.rdata[ST_SCAN_BIT] = m.scanning;
          next_s.rdata[ST_BUSY_BIT] = m.busy;
        end
        OFF_MCMD: begin
          next_s.rdata[CMD_READ_BIT] = s.cmd_read;
          next_s.rdata[CMD_SCAN_BIT] = s.scan_en;
        end
        OFF_MRDATA: begin
          next_s.rdata = m.rd_data;
        end
        OFF_PHS1: begin
          next_s.rdata[PHS1_FDPX_BIT] = 1'b1;
          next_s.rdata[PHS1_HDPX_BIT] = 1'b1;
          next_s.rdata[PHS1_LINK_BIT] = s.link_latch;
          next_s.rdata[PHS1_JAB_BIT] = s.jabber;
        end
        OFF_ID_HIGH: begin
          next_s.rdata = OUI[OUI_W-1:OUI_LOW_W];
        end
        OFF_ID_LOW: begin
          next_s.rdata = {OUI[OUI_LOW_W-1:0], PART_NUM, PHY_REV};
        end
        OFF_SIREV: begin
          next_s.rdata[SIREV_W-1:0] = SI_REV;
        end
        OFF_IRQ_ST: begin
          next_s.rdata[IRQ_W-1:0] = s.irq_st;
        end
        OFF_IRQ_EN: begin
          next_s.rdata[IRQ_W-1:0] = s.irq_en;
        end
        default: begin
          next_s.rdata = '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= REGS_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign irq = |(s.irq_st & s.irq_en);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_link_drop: assert property (ce && !link_up |=> !s.link_latch)
    else $error("link drop not latched low");
  chk_jabber_hold: assert property (ce && jabber_det |=> s.jabber)
    else $error("jabber event not latched high");
  chk_phs1_layout: assert property (ce && hit(rd, addr, OFF_PHS1) |=>
      rdata[PHS1_FDPX_BIT] && rdata[PHS1_HDPX_BIT] && (rdata & PHS1_ZERO_MASK) == '0 &&
      rdata[PHS1_LINK_BIT] == $past(s.link_latch))
    else $error("status one read word malformed");
  chk_ident_low: assert property (ce && hit(rd, addr, OFF_ID_LOW) |=>
      rdata == {OUI[OUI_LOW_W-1:0], PART_NUM, PHY_REV})
    else $error("low ident word wrong");
  chk_mstat_read: assert property (ce && hit(rd, addr, OFF_MSTAT) |=>
      rdata[ST_BUSY_BIT] == $past(m.busy) && rdata[DATA_W-1:ST_READ_DATA_INVALID_FLAG_BIT+1] == '0)
    else $error("management status read word wrong");
endmodule
`default_nettype wire

// ### pkg/pmsr_mgmt_if.sv
// link between the register bank and its management engine
`timescale 1ns/1ps
`default_nettype none
interface pmsr_mgmt_if;
  logic start_read;
  logic start_write;
  logic scan_en;
  logic [15:0] phy_data;
  logic busy;
  logic scanning;
  logic read_data_invalid_flag;
  logic done;
  logic [15:0] rd_data;
  modport ctl (output start_read, start_write, scan_en, phy_data,
               input busy, scanning, read_data_invalid_flag, done, rd_data);
  modport eng (input start_read, start_write, scan_en, phy_data,
               output busy, scanning, read_data_invalid_flag, done, rd_data);
endinterface
`default_nettype wire

// ### pkg/pmsr_pkg.sv
// shared constants and types for the phy management status register bank
package pmsr_pkg;

  // ----------------------------------------------------------------
  // bus shape and timing
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CLK_NS = 20;
  localparam int MGMT_OP_NS = 10240; // one management read or write, 10.24 us
  localparam int MGMT_OP_CYC = MGMT_OP_NS / CLK_NS;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_MSTAT = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_MCMD = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_MRDATA = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_PHS1 = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_ID_HIGH = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_ID_LOW = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_SIREV = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ST = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 4'h9;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_SCAN_BIT = 1;
  localparam int ST_READ_DATA_INVALID_FLAG_BIT = 2;
  localparam int CMD_READ_BIT = 0;
  localparam int CMD_SCAN_BIT = 1;
  localparam int CMD_WRITE_BIT = 2;
  localparam int PHS1_JAB_BIT = 1;
  localparam int PHS1_LINK_BIT = 2;
  localparam int PHS1_HDPX_BIT = 11;
  localparam int PHS1_FDPX_BIT = 12;
  localparam logic [DATA_W-1:0] PHS1_ZERO_MASK = 16'he7f9;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_LINK_BIT = 1;
  localparam int IRQ_JAB_BIT = 2;
  localparam int IRQ_W = 3;

  // ----------------------------------------------------------------
  // identification field widths
  // ----------------------------------------------------------------
  localparam int OUI_W = 22;
  localparam int OUI_LOW_W = OUI_W - DATA_W;
  localparam int PART_W = 6;
  localparam int PREV_W = 4;
  localparam int SIREV_W = 5;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_SCAN} pmsr_state_t;

endpackage

// ### test/pmsr_regs_tb_top.sv
// self-checking bench for the phy management status and ident register bank
`timescale 1ns/1ps
`default_nettype none
module pmsr_regs_tb_top;
  import pmsr_pkg::*;

  // ----------------------------------------------------------------
  // settings and stimulus signals
  // ----------------------------------------------------------------
  localparam int T_OP = 4; // short management operation keeps the run brief
  localparam logic [OUI_W-1:0] T_OUI = 22'h0b4c3d; // arbitrary value
  localparam logic [PART_W-1:0] T_PART = 6'h2b; // arbitrary value
  localparam logic [PREV_W-1:0] T_REV = 4'h6; // arbitrary value
  localparam logic [SIREV_W-1:0] T_SIREV = 5'h13; // arbitrary value

  typedef struct {logic [ADDR_W-1:0] a; logic [DATA_W-1:0] exp;} pmsr_row_t;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic irq;
  logic link_up = 1'b1;
  logic jabber_det = 1'b0;
  logic [DATA_W-1:0] phy_reg_data = 16'h0000;
  int num_errors = 0;
  int checked = 0;
  logic [DATA_W-1:0] d;
  pmsr_row_t rows [8];

  pmsr_regs #(.OUI(T_OUI), .PART_NUM(T_PART), .PHY_REV(T_REV), .SI_REV(T_SIREV),
    .OP_CYC(T_OP)) DUT (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .link_up(link_up),
    .jabber_det(jabber_det), .phy_reg_data(phy_reg_data));

  // 50 mhz clock
  initial begin
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                     input string msg);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // data is taken after the sampling edge has settled, the only cycle it stands
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // bounded poll of the status word, gives up after 40 reads
  task automatic poll(input logic [DATA_W-1:0] mask, input logic [DATA_W-1:0] val);
    logic [DATA_W-1:0] s;
    int n;
    n = 0;
    do begin
      rd_reg(OFF_MSTAT, s);
      n++;
    end while (((s & mask) !== val) && n < 40);
    chk(s & mask, val, "status poll");
  endtask

  task automatic print_verdict();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    print_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rows = '{'{OFF_MSTAT, 16'h0000}, '{OFF_PHS1, 16'h1800}, '{OFF_PHS1, 16'h1804},
             '{OFF_ID_HIGH, T_OUI[21:6]}, '{OFF_ID_LOW, {T_OUI[5:0], T_PART, T_REV}},
             '{OFF_SIREV, {11'h000, T_SIREV}}, '{4'ha, 16'h0000}, '{4'hf, 16'h0000}};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // every row first tries a write, which must leave the read value alone
    foreach (rows[i]) begin
      wr_reg(rows[i].a, 16'hffff);
      rd_reg(rows[i].a, d);
      chk(d, rows[i].exp, "row read");
    end
    // read data stand only in the cycle after the strobe, so look one edge later
    @(posedge clk);
    #1 chk({15'h0000, rdata === 16'h0000}, 16'h0001, "rdata stands one cycle");
    // jabber latches high, masked first, then enabled
    wr_reg(OFF_IRQ_EN, 16'h0000);
    @(posedge clk) jabber_det <= 1'b1;
    @(posedge clk) jabber_det <= 1'b0;
    repeat (2) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000, "masked irq");
    rd_reg(OFF_IRQ_ST, d);
    chk(d & 16'h0004, 16'h0004, "jabber irq status");
    wr_reg(OFF_IRQ_EN, 16'h0004);
    #1 chk({15'h0000, irq}, 16'h0001, "enabled irq");
    rd_reg(OFF_PHS1, d);
    chk(d, 16'h1806, "jabber latched");
    rd_reg(OFF_PHS1, d);
    chk(d, 16'h1804, "jabber cleared by read");
    wr_reg(OFF_IRQ_CLR, 16'h0007);
    #1 chk({15'h0000, irq}, 16'h0000, "irq cleared");
    // one-cycle link drop must latch low until the next read
    @(posedge clk) link_up <= 1'b0;
    @(posedge clk) link_up <= 1'b1;
    rd_reg(OFF_PHS1, d);
    chk(d, 16'h1800, "link drop latched");
    rd_reg(OFF_PHS1, d);
    chk(d, 16'h1804, "link back up");
    rd_reg(OFF_IRQ_ST, d);
    chk(d & 16'h0002, 16'h0002, "link fell irq status");
    // single management read, busy clears by itself
    phy_reg_data <= 16'hbeef;
    wr_reg(OFF_IRQ_EN, 16'h0001);
    wr_reg(OFF_MCMD, 16'h0001);
    rd_reg(OFF_MSTAT, d);
    chk(d, 16'h0005, "read in flight");
    poll(16'hffff, 16'h0000);
    rd_reg(OFF_MRDATA, d);
    chk(d, 16'hbeef, "read data");
    chk({15'h0000, irq}, 16'h0001, "done irq");
    wr_reg(OFF_IRQ_CLR, 16'h0001);
    wr_reg(OFF_MCMD, 16'h0000);
    // scan refreshes read data every interval until cancelled
    phy_reg_data <= 16'h1234;
    wr_reg(OFF_MCMD, 16'h0002);
    rd_reg(OFF_MSTAT, d);
    chk(d & 16'h0003, 16'h0003, "scan busy");
    poll(16'h0006, 16'h0002);
    rd_reg(OFF_MRDATA, d);
    chk(d, 16'h1234, "first scan data");
    phy_reg_data <= 16'h5678;
    repeat (3 * T_OP) @(posedge clk);
    rd_reg(OFF_MRDATA, d);
    chk(d, 16'h5678, "scan refresh");
    wr_reg(OFF_MCMD, 16'h0000);
    poll(16'h0003, 16'h0000);
    // write operation: busy without a done event
    wr_reg(OFF_IRQ_CLR, 16'h0007);
    wr_reg(OFF_MCMD, 16'h0004);
    rd_reg(OFF_MSTAT, d);
    chk(d, 16'h0001, "write in flight");
    poll(16'h0007, 16'h0000);
    rd_reg(OFF_IRQ_ST, d);
    chk(d & 16'h0001, 16'h0000, "write raises no done");
    // clock enable low freezes the read data word
    rd_reg(OFF_SIREV, d);
    ce <= 1'b0;
    @(posedge clk);
    #1 chk(rdata, {11'h000, T_SIREV}, "ce low holds rdata");
    ce <= 1'b1;
    // reset in mid-run drops outputs
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(rdata, 16'h0000, "rdata in reset");
    chk({15'h0000, irq}, 16'h0000, "irq in reset");
    rst <= 1'b0;
    rd_reg(OFF_PHS1, d);
    chk(d, 16'h1800, "link latch after reset");
    print_verdict();
  end
endmodule
`default_nettype wire
